// file: lpe_consts.vh
// Constants for the low-power, reduce-speed and error state block
// Notes on behaviour
// [R01] Partial exits to wake burst once recovered
// [R02] Stay in partial until recovery completes
// [R03] Partial to slumber only when auto enabled
// [R04] Stay in slumber while requested or unrecovered
// [R05] Slumber exits to wake burst once recovered
// [R06] Reduce speed waits for valid slower signal
// [R07] Failed resume error retries the wake burst
// [R08] Other error goes to reset after interval; the code does so only when the async recovery bit is set
// [R09] Error holds otherwise or before interval ends
// [R10] Ready flag only in ready, synced, valid
// [R11] Resume failure never lowers speed; error instead
// [R12] Transmitter quiescent in all four states
// [R13] Host wake on exit awaits its negation
`ifndef LPE_CONSTS_VH
`define LPE_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define LPE_OFS_CTRL       12'h000
`define LPE_OFS_STATUS     12'h004
`define LPE_OFS_INT_STAT   12'h008
`define LPE_OFS_INT_MASK   12'h00c
`define LPE_OFS_RETRY      12'h010

// ****************************************
// Field positions and reset values
// ****************************************
`define LPE_CTRL_AUTO_SLUMBER_BIT 0
`define LPE_CTRL_ASYNC_REC_BIT    1
`define LPE_CTRL_RESET            2'h0
`define LPE_INT_WIDTH             4
`define LPE_INT_ERROR_BIT         0
`define LPE_INT_RETRY_WAKE_BIT    1
`define LPE_INT_RETRY_RESET_BIT   2
`define LPE_INT_SPEED_DONE_BIT    3
`define LPE_INT_MASK_RESET        4'h0
`define LPE_RETRY_WIDTH           16
`define LPE_RETRY_RESET           16'h000a

// ****************************************
// Timing
// ****************************************
`define LPE_CLK_MHZ        10
`define LPE_TICK_NS        1000
`define LPE_CLK_NS         100
`define LPE_TICK_CYCLES    (`LPE_TICK_NS / `LPE_CLK_NS)
`define LPE_TICK_LAST      8'h09

// ****************************************
// States
// ****************************************
`define LPE_ST_IDLE        3'h0
`define LPE_ST_PARTIAL     3'h1
`define LPE_ST_SLUMBER     3'h2
`define LPE_ST_REDUCE      3'h3
`define LPE_ST_ERROR       3'h4

`endif

// file: lpe_retry_timer.v
// Retry interval timer counting microsecond ticks
`timescale 1ns/1ps
`include "lpe_consts.vh"

module lpe_retry_timer (
    // Clock and reset
    input  wire                         pclk,
    input  wire                         presetn,
    // Control
    input  wire                         restart,
    input  wire [`LPE_RETRY_WIDTH-1:0]  limit,
    // Result
    output reg                          elapsed_q
);

    // ****************************************
    // Microsecond tick divider
    // ****************************************
    localparam [7:0] TICK_LAST = `LPE_TICK_LAST;   // Last divider count of a microsecond

    reg [7:0]                  div_q;     // Cycle divider
    reg                        tick_q;    // One-cycle microsecond enable
    reg [`LPE_RETRY_WIDTH-1:0] count_q;   // Elapsed ticks since restart

    // Divider restarts with the timer so the first tick is a full period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (restart) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (div_q == TICK_LAST) begin
            div_q  <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // ****************************************
    // Interval counter
    // ****************************************
    // Saturates at limit; elapsed stays high until next restart
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q   <= {`LPE_RETRY_WIDTH{1'b0}};
            elapsed_q <= 1'b0;
        end else if (restart) begin
            count_q   <= {`LPE_RETRY_WIDTH{1'b0}};
            elapsed_q <= 1'b0;
        end else if (count_q >= limit) begin
            elapsed_q <= 1'b1;
        end else if (tick_q) begin
            count_q   <= count_q + {{(`LPE_RETRY_WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// file: lpe_fsm_top.v
// Device link power states, reduce-speed and error state machine with APB registers
`timescale 1ns/1ps
`include "lpe_consts.vh"

module lpe_fsm_top (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Entry requests from the surrounding state machine
    input  wire        enter_partial,
    input  wire        enter_slumber,
    input  wire        enter_reduce,
    input  wire        enter_error,
    input  wire        error_resume_fail,
    input  wire        in_ready_state,
    // Link layer requests
    input  wire        link_partial_req,
    input  wire        link_slumber_req,
    // Analog front-end status (asynchronous)
    input  wire        phy_recovered,
    input  wire        host_wake_seen,
    input  wire        tx_speed_valid,
    input  wire        rx_sync,
    input  wire        tx_signal_valid,
    // Exits to the surrounding state machine
    output reg         go_wake_burst,
    output reg         go_await_no_wake,
    output reg         go_send_align,
    output reg         go_reset,
    output reg         tx_quiet,
    output reg         resume_active,
    output reg         phy_ready_out,
    output reg         irq
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Front-end levels arrive from another domain
    reg [4:0] sync1_q;   // First stage, read only by second stage
    reg [4:0] sync2_q;   // Second stage, safe to use

    // Two flops per level; only the second stage feeds logic
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {tx_signal_valid, rx_sync, tx_speed_valid, host_wake_seen, phy_recovered};
            sync2_q <= sync1_q;
        end
    end

    // Synchronised copies, two cycles behind the pins
    wire recovered_s = sync2_q[0];   // Phy ready to communicate again
    wire host_wake_s = sync2_q[1];   // Host wake burst present
    wire speed_ok_s  = sync2_q[2];   // Transmitter valid at slower speed
    wire rx_sync_s   = sync2_q[3];   // Receiver locked
    wire tx_valid_s  = sync2_q[4];   // Transmitter valid

    // ****************************************
    // Register file
    // ****************************************
    // Software-visible registers and the state
    reg [1:0]                  ctrl_q;       // Auto slumber and async recovery
    reg [`LPE_INT_WIDTH-1:0]   int_stat_q;   // Sticky events
    reg [`LPE_INT_WIDTH-1:0]   int_mask_q;   // Interrupt enables
    reg [`LPE_RETRY_WIDTH-1:0] retry_q;      // Retry interval in microseconds
    reg [2:0]                  state_q;      // Current state
    reg [2:0]                  state_d;      // Next state
    reg                        resume_fail_q; // Error caused by failed resume
    reg [`LPE_INT_WIDTH-1:0]   event_d;      // Events raised this cycle

    // Bus access handshake: one wait state
    // The first access cycle loads the answer; pready follows a cycle later
    // Writes land at the edge where pready is sampled high
    wire access   = psel & penable & ~pready;
    wire wr_en    = psel & penable & pready & pwrite;
    wire auto_slp = ctrl_q[`LPE_CTRL_AUTO_SLUMBER_BIT];
    wire async_ok = ctrl_q[`LPE_CTRL_ASYNC_REC_BIT];

    // Address decode used by the error path; the read multiplexer decodes on its own
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `LPE_OFS_CTRL) || (a == `LPE_OFS_STATUS) || (a == `LPE_OFS_INT_STAT)
                  || (a == `LPE_OFS_INT_MASK) || (a == `LPE_OFS_RETRY);
        end
    endfunction

    // Read multiplexer
    // Status word: resume flag, error cause, state code
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `LPE_OFS_CTRL:     rdata_d = {30'h0, ctrl_q};
            `LPE_OFS_STATUS:   rdata_d = {27'h0, resume_active, resume_fail_q, state_q};
            `LPE_OFS_INT_STAT: rdata_d = {28'h0, int_stat_q};
            `LPE_OFS_INT_MASK: rdata_d = {28'h0, int_mask_q};
            `LPE_OFS_RETRY:    rdata_d = {16'h0, retry_q};
            default:           rdata_d = 32'h0000_0000;
        endcase
    end

    // APB answer, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            // Answer one cycle after the access cycle is taken
            pready  <= access;
            // Error flag only for offsets outside the map
            pslverr <= access & ~mapped(paddr);
            // Read data stands until the next read
            if (access && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // Writable registers; a set event wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `LPE_CTRL_RESET;
            int_mask_q <= `LPE_INT_MASK_RESET;
            retry_q    <= `LPE_RETRY_RESET;
            int_stat_q <= {`LPE_INT_WIDTH{1'b0}};
        end else begin
            // Control bits
            if (wr_en && paddr == `LPE_OFS_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
            // Interrupt enables
            if (wr_en && paddr == `LPE_OFS_INT_MASK) begin
                int_mask_q <= pwdata[`LPE_INT_WIDTH-1:0];
            end
            // Retry interval in microseconds
            if (wr_en && paddr == `LPE_OFS_RETRY) begin
                retry_q <= pwdata[`LPE_RETRY_WIDTH-1:0];
            end
            // Write one to clear; a same-cycle event keeps its bit
            if (wr_en && paddr == `LPE_OFS_INT_STAT) begin
                int_stat_q <= (int_stat_q & ~pwdata[`LPE_INT_WIDTH-1:0]) | event_d;
            end else begin
                int_stat_q <= int_stat_q | event_d;
            end
        end
    end

    // ****************************************
    // Retry interval timer
    // ****************************************
    // Entry edge into error; each visit restarts the interval afresh
    wire error_entry = (state_q != `LPE_ST_ERROR) && (state_d == `LPE_ST_ERROR);
    wire retry_done;   // Interval elapsed since entry

    // Timer runs on its own microsecond divider
    lpe_retry_timer lpe_retry_timer_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .restart   (error_entry),
        .limit     (retry_q),
        .elapsed_q (retry_done)
    );

    // ****************************************
    // Next state and exits
    // ****************************************
    // One-cycle exit strobes, registered below
    reg wake_d;    // Exit to wake burst
    reg await_d;   // Exit to await wake negation
    reg align_d;   // Exit to send alignment
    reg reset_d;   // Exit to reset

    // Exits read front-end levels only through their synchronised copies
    always @* begin
        state_d = state_q;
        wake_d  = 1'b0;
        await_d = 1'b0;
        align_d = 1'b0;
        reset_d = 1'b0;
        event_d = {`LPE_INT_WIDTH{1'b0}};
        case (state_q)
            `LPE_ST_IDLE: begin
                // Entry from the surrounding machine
                // Priority: error, reduce, slumber, partial
                if (enter_error) begin
                    state_d = `LPE_ST_ERROR;
                    event_d[`LPE_INT_ERROR_BIT] = 1'b1;
                end else if (enter_reduce && resume_active) begin
                    // No speed drop while resuming; retry the wake instead
                    state_d = `LPE_ST_ERROR;                      // R11
                    event_d[`LPE_INT_ERROR_BIT] = 1'b1;
                end else if (enter_reduce) begin
                    state_d = `LPE_ST_REDUCE;
                end else if (enter_slumber) begin
                    state_d = `LPE_ST_SLUMBER;
                end else if (enter_partial) begin
                    state_d = `LPE_ST_PARTIAL;
                end
            end
            `LPE_ST_PARTIAL: begin
                // Host wake picks the await exit over our own burst
                if (!link_partial_req && recovered_s) begin
                    state_d = `LPE_ST_IDLE;
                    await_d = host_wake_s;                        // R13
                    wake_d  = ~host_wake_s;                       // R01
                end else if (link_slumber_req && auto_slp) begin
                    state_d = `LPE_ST_SLUMBER;                    // R03
                end
                // Otherwise hold while unrecovered or requested  // R02
            end
            `LPE_ST_SLUMBER: begin
                // Same exit choice as partial
                if (!link_slumber_req && recovered_s) begin
                    state_d = `LPE_ST_IDLE;
                    await_d = host_wake_s;                        // R13
                    wake_d  = ~host_wake_s;                       // R05
                end
                // Hold while requested or unrecovered            // R04
            end
            `LPE_ST_REDUCE: begin
                // Leave once the transmitter is valid at the slower rate
                if (speed_ok_s) begin
                    state_d = `LPE_ST_IDLE;
                    align_d = 1'b1;                               // R06
                    event_d[`LPE_INT_SPEED_DONE_BIT] = 1'b1;
                end
            end
            `LPE_ST_ERROR: begin
                // A failed resume always retries the wake first
                if (resume_fail_q) begin
                    state_d = `LPE_ST_IDLE;
                    wake_d  = 1'b1;                               // R07
                    event_d[`LPE_INT_RETRY_WAKE_BIT] = 1'b1;
                end else if (async_ok && retry_done) begin
                    state_d = `LPE_ST_IDLE;
                    reset_d = 1'b1;                               // R08
                    event_d[`LPE_INT_RETRY_RESET_BIT] = 1'b1;
                end
                // Otherwise remain in error                      // R09
            end
            default: begin
                // Unused codes fall back to idle
                state_d = `LPE_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // State and output flops
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q          <= `LPE_ST_IDLE;
            resume_fail_q    <= 1'b0;
            resume_active    <= 1'b0;
            go_wake_burst    <= 1'b0;
            go_await_no_wake <= 1'b0;
            go_send_align    <= 1'b0;
            go_reset         <= 1'b0;
            tx_quiet         <= 1'b0;
            phy_ready_out    <= 1'b0;
            irq              <= 1'b0;
        end else begin
            state_q          <= state_d;
            // Exit strobes last one cycle
            go_wake_burst    <= wake_d;
            go_await_no_wake <= await_d;
            go_send_align    <= align_d;
            go_reset         <= reset_d;
            // Quiet in every owned state
            tx_quiet         <= (state_d != `LPE_ST_IDLE);                   // R12
            // Ready only in ready state with lock and valid transmit
            phy_ready_out    <= in_ready_state & rx_sync_s & tx_valid_s;     // R10
            // Interrupt level from unmasked sticky bits
            irq              <= |(int_stat_q & int_mask_q);
            // Capture error cause; resume errors force a wake retry
            if (state_q == `LPE_ST_IDLE && (enter_error || (enter_reduce && resume_active))) begin
                resume_fail_q <= error_resume_fail | resume_active;          // R11
            end
            // Resume in progress from any wake or await exit, including the error retry, until ready
            if (wake_d || await_d) begin
                resume_active <= 1'b1;                                       // R11
            end else if (in_ready_state && rx_sync_s && tx_valid_s) begin
                resume_active <= 1'b0;
            end
        end
    end

endmodule

// file: lpe_properties.sv
// Checker for entry, exit, quiet and ready behaviour at the block ports
`timescale 1ns/1ps
module lpe_properties (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Entry pulses and front-end levels
    input logic enter_partial,
    input logic enter_slumber,
    input logic enter_reduce,
    input logic enter_error,
    input logic in_ready_state,
    input logic phy_recovered,
    input logic host_wake_seen,
    input logic tx_speed_valid,
    // Exit pulses and levels
    input logic go_wake_burst,
    input logic go_await_no_wake,
    input logic go_send_align,
    input logic go_reset,
    input logic tx_quiet,
    input logic phy_ready_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] quiet_q; // Cycles spent quiet in a row
    logic        exit_w;  // Any exit pulse
    assign exit_w = go_wake_burst | go_await_no_wake | go_send_align | go_reset;
    // ****************************************
    // Quiet-time counter
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_q <= 16'h0;
        else quiet_q <= tx_quiet ? quiet_q + 16'h1 : 16'h0;
    end
    // Entry taken while idle
    sequence s_enter;
        !tx_quiet && (enter_partial || enter_slumber || enter_reduce || enter_error);
    endsequence
    quiet_entry_a: assert property (s_enter |=> tx_quiet) else $error("no quiet after entry");
    exit_quiet_a: assert property (exit_w |-> !tx_quiet) else $error("quiet at exit");
    exit_once_a: assert property (exit_w |=> !exit_w) else $error("exit pulse too long");
    exit_onehot_a: assert property ($onehot0({go_wake_burst, go_await_no_wake, go_send_align, go_reset}))
        else $error("two exits at once");
    ready_gate_a: assert property (phy_ready_out |-> $past(in_ready_state)) else $error("ready out of state");
    wake_cause_a: assert property (go_await_no_wake |-> $past(phy_recovered, 3) && $past(host_wake_seen, 3))
        else $error("await exit without cause");
    align_valid_a: assert property (go_send_align |-> $past(tx_speed_valid, 3)) else $error("align too early");
    retry_wait_a: assert property (go_reset |-> $past(quiet_q) >= 16'd10) else $error("reset before interval");
endmodule
bind lpe_fsm_top lpe_properties lpe_properties_inst (
    .pclk             (pclk),
    .presetn          (presetn),
    .enter_partial    (enter_partial),
    .enter_slumber    (enter_slumber),
    .enter_reduce     (enter_reduce),
    .enter_error      (enter_error),
    .in_ready_state   (in_ready_state),
    .phy_recovered    (phy_recovered),
    .host_wake_seen   (host_wake_seen),
    .tx_speed_valid   (tx_speed_valid),
    .go_wake_burst    (go_wake_burst),
    .go_await_no_wake (go_await_no_wake),
    .go_send_align    (go_send_align),
    .go_reset         (go_reset),
    .tx_quiet         (tx_quiet),
    .phy_ready_out    (phy_ready_out)
);

// file: lpe_host_model.sv
// Host side model: wake burst seen by the device receiver
`timescale 1ns/1ps
module lpe_host_model (
    // Clock
    input  logic pclk,
    // Bench command: host sends a wake burst
    input  logic wake_cmd,
    // Wake burst detected at the device
    output logic host_wake_seen
);
    int dly = 0; // Lag before the burst is seen
    // Answer promptly or slowly, hold while commanded
    always @(posedge pclk) begin
        if (!wake_cmd) begin
            host_wake_seen <= 1'b0;
            dly = $urandom % 4;
        end else if (dly > 0) dly--;
        else host_wake_seen <= 1'b1;
    end
endmodule

// file: tb_device_phy_lowpower_speed_error_fsm.sv
// Self-checking bench for the low-power, reduce-speed and error block
`timescale 1ns/1ps
module tb_device_phy_lowpower_speed_error_fsm;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  ent = 4'h0; // Entry pulses: error, reduce, slumber, partial
    logic fail_in = 0, ready_in = 0, preq = 0, sreq = 0, recov = 0, wake_cmd = 0, spd = 0, sync = 0, txv = 0;
    wire [31:0] prdata;
    wire pready, pslverr, gw, ga, gs, gr, txq, ract, prdy, irq, hw;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    logic [3:0]  eq[$]; // Expected exits: wake, await, align, reset
    logic [33:0] rq[$]; // Expected irq, slave error, read data
    always #50 pclk = ~pclk;
    lpe_fsm_top lpe_fsm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enter_partial(ent[0]), .enter_slumber(ent[1]), .enter_reduce(ent[2]), .enter_error(ent[3]),
        .error_resume_fail(fail_in), .in_ready_state(ready_in), .link_partial_req(preq),
        .link_slumber_req(sreq), .phy_recovered(recov), .host_wake_seen(hw), .tx_speed_valid(spd),
        .rx_sync(sync), .tx_signal_valid(txv), .go_wake_burst(gw), .go_await_no_wake(ga),
        .go_send_align(gs), .go_reset(gr), .tx_quiet(txq), .resume_active(ract),
        .phy_ready_out(prdy), .irq(irq));
    lpe_host_model lpe_host_model_inst (.pclk(pclk), .wake_cmd(wake_cmd), .host_wake_seen(hw));
    task automatic conclude();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_ex(input logic [3:0] e, input logic [3:0] g);
        comparisons++;
        if (g !== e) begin error_cnt++; $display("FAIL t=%0t exp=%h got=%h", $time, e, g); end
    endtask
    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin error_cnt++; $display("FAIL t=%0t exp=%h got=%h", $time, e, g); end
    endtask
    // Match exit pulses and read answers to the oldest note, cut hangs
    always @(posedge pclk) begin
        if (gw | ga | gs | gr) cmp_ex(eq.size() ? eq.pop_front() : 4'h0, {gw, ga, gs, gr});
        if (pready && !pwrite) cmp_rd(rq.size() ? rq.pop_front() : 34'h0, {irq, pslverr, prdata});
        cyc++;
        if (cyc == 20000) begin error_cnt++; conclude(); end
    end
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        apb(0, a, 32'h0);
    endtask
    task automatic go(input logic [3:0] v);
        @(posedge pclk) ent <= v;
        @(posedge pclk) ent <= 4'h0;
    endtask
    task automatic settle(); repeat (30) @(posedge pclk); endtask
    task automatic drain(); while (eq.size()) @(posedge pclk); repeat (2) @(posedge pclk); endtask
    // Ready flag follows state, sync and valid; also ends any resume
    task automatic rdy();
        cmp_rd(34'h1, {33'h0, ract});
        ready_in <= 1; sync <= 1; txv <= 1;
        repeat (5) @(posedge pclk);
        cmp_rd(34'h2, {32'h0, prdy, ract});
        sync <= 0;
        repeat (5) @(posedge pclk);
        cmp_rd(34'h0, {33'h0, prdy});
        ready_in <= 0; txv <= 0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int r, t0;
        void'($urandom(32'h11bcdb95));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        rd(12'h000, 34'h0); rd(12'h008, 34'h0); rd(12'h00c, 34'h0); rd(12'h010, 34'h00a);
        rd(12'h014, 34'h1_0000_0000);
        // Partial waits for recovery
        go(4'h1); settle();
        eq.push_back(4'h8); recov <= 1; drain(); rdy();
        // No slumber hop while auto is off
        preq <= 1; sreq <= 1; go(4'h1); settle(); rd(12'h004, 34'h1);
        eq.push_back(4'h8); preq <= 0; sreq <= 0; drain(); rdy();
        apb(1, 12'h000, 32'h1);
        for (int w = 0; w < 2; w++) begin
            preq <= 1; sreq <= 1; go(4'h1); settle(); rd(12'h004, 34'h2);
            wake_cmd <= w[0]; settle();
            eq.push_back(w ? 4'h4 : 4'h8); sreq <= 0; preq <= 0; drain(); rdy();
            wake_cmd <= 0;
        end
        // Reduce speed waits for a valid signal
        go(4'h4); settle(); eq.push_back(4'h2); spd <= 1; drain(); spd <= 0;
        fail_in <= 1; eq.push_back(4'h8); go(4'h8); drain(); fail_in <= 0;
        eq.push_back(4'h8); go(4'h4); drain(); rdy();
        go(4'h8); settle(); settle();
        presetn <= 0; repeat (3) @(posedge pclk); presetn <= 1;
        // Retry interval then reset, with interrupt handling
        r = $urandom % 3 + 1;
        apb(1, 12'h000, 32'h2); apb(1, 12'h010, r); apb(1, 12'h00c, 32'hf);
        t0 = cyc; eq.push_back(4'h1); go(4'h8); drain();
        cmp_rd(34'h1, {33'h0, (cyc - t0) >= r * 10});
        rd(12'h008, 34'h2_0000_0005);
        apb(1, 12'h00c, 32'h0); rd(12'h008, 34'h5);
        apb(1, 12'h008, 32'h5); rd(12'h008, 34'h0);
        conclude();
    end
endmodule
